// ===== core/bcb_pkg.sv
// Package for the channel B break compare block: register map, fields and encodings
package bcb_pkg;
    // Register byte offsets on the APB
    localparam logic [7:0] OFS_ADDR = 8'h00;
    localparam logic [7:0] OFS_AMASK = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_DMASK = 8'h0C;
    localparam logic [7:0] OFS_QUAL = 8'h10;
    localparam logic [7:0] OFS_CTRL = 8'h14;
    localparam logic [7:0] OFS_STAT = 8'h18;
    // Reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [7:0] RST_QUAL = 8'h00;
    // Qualifier field positions (low bit of each two-bit field)
    localparam int POS_BUS = 6;
    localparam int POS_TYPE = 4;
    localparam int POS_DIR = 2;
    localparam int POS_SIZE = 0;
    // Stored width of the qualifier, upper byte reads zero
    localparam int QUAL_W = 8;
    // Control and status bit positions
    localparam int POS_DCMP = 0;
    localparam int POS_ST_L = 0;
    localparam int POS_ST_I = 1;
    // Field encodings
    localparam logic [1:0] SEL_OFF = 2'h0;
    localparam logic [1:0] BUS_L = 2'h1;
    localparam logic [1:0] BUS_I = 2'h2;
    localparam logic [1:0] BUS_L2 = 2'h3;
    localparam logic [1:0] SEL_A = 2'h1;
    localparam logic [1:0] SEL_B = 2'h2;
    localparam logic [1:0] SEL_BOTH = 2'h3;
    localparam logic [1:0] SZ_BYTE = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    localparam logic [1:0] SZ_LONG = 2'h3;
    // Lanes compared for byte and word data, then for long data or a zero size field
    localparam logic [31:0] LANE_LOW16 = 32'h0000_FFFF;
    localparam logic [31:0] LANE_ALL = 32'hFFFF_FFFF;

    // Complete state of the block
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] amask;
        logic [31:0] data;
        logic [31:0] dmask;
        logic [QUAL_W-1:0] qual;
        logic dcmp;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic match_l;
        logic match_i;
        logic match;
    } bcb_state_t;
endpackage : bcb_pkg

// ===== core/bcb_compare.sv
// Channel B break condition registers and bus cycle comparator with APB slave
// Functional notes
// (RL1) Hold break address, compare against address bus
// (RL2) Address mask bit 1 excludes that bit
// (RL3) Hold break data, compare when enabled
// (RL4) Data mask bit 1 excludes that bit
// (RL5) Software sets nonzero size for data compare
// (RL6) Byte size: software duplicates data byte
// (RL7) Byte size: software duplicates mask byte
// (RL8) Bus field: 00 off, 01/11 L, 10 I
// (RL9) Type field: 00 off, fetch, data, either
// (RL10) Direction field: 00 off, read, write, either
// (RL11) Size field: 00 ignored, byte, word, long
// (RL12) Qualifier bits 15..8 read zero
// (RL13) Four 32-bit registers, RW, reset zero
// (RL14) Qualifier 16 bits, fields reset zero
// (RL15) Match only when all enabled conditions hold
`timescale 1ns/1ps
module bcb_compare (
    input wire logic I_CLOCK,
    input wire logic I_ARST_N,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire logic I_L_CYCLE_VALID,
    input wire logic [31:0] I_L_SIDE_ADDRESS_BUS,
    input wire logic [31:0] I_L_SIDE_DATA_BUS,
    input wire logic I_L_FETCH,
    input wire logic I_L_WRITE,
    input wire logic [1:0] I_L_SIZE,
    input wire logic I_I_CYCLE_VALID,
    input wire logic [31:0] I_I_SIDE_ADDRESS_BUS,
    input wire logic [31:0] I_I_SIDE_DATA_BUS,
    input wire logic I_I_FETCH,
    input wire logic I_I_WRITE,
    input wire logic [1:0] I_I_SIZE,
    output logic O_MATCH_L_B,
    output logic O_MATCH_I_B,
    output logic O_MATCH_B
);
    // Registered state and its next value
    bcb_pkg::bcb_state_t state_q;
    bcb_pkg::bcb_state_t state_d;
    // Completion edge of an APB access
    logic apb_done;
    // First access cycle, where the answer is prepared
    logic apb_first;

    // Compare one bus cycle against every enabled condition
    function automatic logic bcb_hit(
        input logic vld,
        input logic ibus,
        input logic [31:0] a,
        input logic [31:0] d,
        input logic fetch,
        input logic wr,
        input logic [1:0] sz,
        input bcb_pkg::bcb_state_t s
    );
        logic [1:0] f_bus;
        logic [1:0] f_typ;
        logic [1:0] f_dir;
        logic [1:0] f_sz;
        logic [31:0] lane;
        logic bus_ok;
        logic typ_ok;
        logic dir_ok;
        logic sz_ok;
        logic a_ok;
        logic d_ok;
        f_bus = s.qual[bcb_pkg::POS_BUS +: 2];
        f_typ = s.qual[bcb_pkg::POS_TYPE +: 2];
        f_dir = s.qual[bcb_pkg::POS_DIR +: 2];
        f_sz = s.qual[bcb_pkg::POS_SIZE +: 2];
        // Bus select, 00 keeps the channel from matching on either bus
        if (ibus) begin
            bus_ok = (f_bus == bcb_pkg::BUS_I); // RL8
        end else begin
            bus_ok = (f_bus == bcb_pkg::BUS_L) || (f_bus == bcb_pkg::BUS_L2); // RL8
        end
        // Fetch or data access
        typ_ok = fetch ? f_typ[0] : f_typ[1]; // RL9
        // Read or write
        dir_ok = wr ? f_dir[1] : f_dir[0]; // RL10
        // Size is a don't-care when the field is zero
        sz_ok = (f_sz == bcb_pkg::SEL_OFF) || (f_sz == sz); // RL11
        // Masked address compare
        a_ok = ((a ^ s.addr) & ~s.amask) == 32'h0000_0000; // RL1 RL2
        // Byte and word data sit on the low lanes
        if ((f_sz == bcb_pkg::SZ_BYTE) || (f_sz == bcb_pkg::SZ_WORD)) begin
            lane = bcb_pkg::LANE_LOW16;
        end else begin
            lane = bcb_pkg::LANE_ALL;
        end
        // Masked data compare, only when enabled
        d_ok = !s.dcmp || (((d ^ s.data) & ~s.dmask & lane) == 32'h0000_0000); // RL3 RL4
        return vld && bus_ok && typ_ok && dir_ok && sz_ok && a_ok && d_ok; // RL15
    endfunction : bcb_hit

    // Access phase decode
    assign apb_first = I_PSEL && I_PENABLE && !state_q.pready;
    assign apb_done = I_PSEL && I_PENABLE && state_q.pready;

    // Next state: register file, APB answer and match
    always_comb begin
        state_d = state_q;
        state_d.pready = 1'b0;
        state_d.pslverr = 1'b0;
        state_d.prdata = 32'h0000_0000;
        // Prepare the answer one cycle into the access phase
        if (apb_first) begin
            state_d.pready = 1'b1;
            unique case (I_PADDR)
                bcb_pkg::OFS_ADDR: begin
                    state_d.prdata = state_q.addr;
                end
                bcb_pkg::OFS_AMASK: begin
                    state_d.prdata = state_q.amask;
                end
                bcb_pkg::OFS_DATA: begin
                    state_d.prdata = state_q.data;
                end
                bcb_pkg::OFS_DMASK: begin
                    state_d.prdata = state_q.dmask;
                end
                bcb_pkg::OFS_QUAL: begin
                    // Upper bits read zero
                    state_d.prdata = {24'h000000, state_q.qual}; // RL12
                end
                bcb_pkg::OFS_CTRL: begin
                    state_d.prdata[bcb_pkg::POS_DCMP] = state_q.dcmp;
                end
                bcb_pkg::OFS_STAT: begin
                    // Read only: last cycle's match per bus
                    state_d.prdata[bcb_pkg::POS_ST_L] = state_q.match_l;
                    state_d.prdata[bcb_pkg::POS_ST_I] = state_q.match_i;
                end
                default: begin
                    // Unmapped address answers with an error
                    state_d.pslverr = 1'b1;
                end
            endcase
        end
        // Writes take effect on the edge that completes the access
        if (apb_done && I_PWRITE) begin
            unique case (I_PADDR)
                bcb_pkg::OFS_ADDR: begin
                    state_d.addr = I_PWDATA; // RL13
                end
                bcb_pkg::OFS_AMASK: begin
                    state_d.amask = I_PWDATA; // RL13
                end
                bcb_pkg::OFS_DATA: begin
                    state_d.data = I_PWDATA; // RL13
                end
                bcb_pkg::OFS_DMASK: begin
                    state_d.dmask = I_PWDATA; // RL13
                end
                bcb_pkg::OFS_QUAL: begin
                    // Upper byte is not stored
                    state_d.qual = I_PWDATA[bcb_pkg::QUAL_W-1:0]; // RL12 RL14
                end
                bcb_pkg::OFS_CTRL: begin
                    state_d.dcmp = I_PWDATA[bcb_pkg::POS_DCMP];
                end
                default: begin
                    // Status and unmapped addresses ignore writes
                    state_d.dcmp = state_q.dcmp;
                end
            endcase
        end
        // Per-bus match, registered one cycle after the bus cycle
        state_d.match_l = bcb_hit(I_L_CYCLE_VALID, 1'b0, I_L_SIDE_ADDRESS_BUS,
            I_L_SIDE_DATA_BUS, I_L_FETCH, I_L_WRITE, I_L_SIZE, state_q);
        state_d.match_i = bcb_hit(I_I_CYCLE_VALID, 1'b1, I_I_SIDE_ADDRESS_BUS,
            I_I_SIDE_DATA_BUS, I_I_FETCH, I_I_WRITE, I_I_SIZE, state_q);
        state_d.match = state_d.match_l || state_d.match_i; // RL15
    end

    // State register, all fields cleared at reset
    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            state_q.addr <= bcb_pkg::RST_WORD; // RL13
            state_q.amask <= bcb_pkg::RST_WORD;
            state_q.data <= bcb_pkg::RST_WORD;
            state_q.dmask <= bcb_pkg::RST_WORD;
            state_q.qual <= bcb_pkg::RST_QUAL; // RL14
            state_q.dcmp <= 1'b0;
            state_q.pready <= 1'b0;
            state_q.pslverr <= 1'b0;
            state_q.prdata <= bcb_pkg::RST_WORD;
            state_q.match_l <= 1'b0;
            state_q.match_i <= 1'b0;
            state_q.match <= 1'b0;
        end else begin
            state_q <= state_d;
        end
    end

    // Outputs straight from the state register
    assign O_PRDATA = state_q.prdata;
    assign O_PREADY = state_q.pready;
    assign O_PSLVERR = state_q.pslverr;
    assign O_MATCH_L_B = state_q.match_l;
    assign O_MATCH_I_B = state_q.match_i;
    assign O_MATCH_B = state_q.match;

    // Qualifier readback never shows the upper byte
    AST_QUAL_UPPER_ZERO: assert property ( // RL12
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        (apb_first && I_PADDR == bcb_pkg::OFS_QUAL) |=> (O_PRDATA[31:8] == 24'h000000)
    ) else $error("qualifier upper byte read nonzero");

    // An L match implies the masked address agreed
    AST_ADDR_MASKED: assert property ( // RL1
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        O_MATCH_L_B |-> ((($past(I_L_SIDE_ADDRESS_BUS) ^ $past(state_q.addr))
            & ~$past(state_q.amask)) == 32'h0000_0000)
    ) else $error("L match with differing unmasked address bits");

    // Fully masked address plus both-way fields gives an I match
    AST_MASK_ALL: assert property ( // RL2
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        (I_I_CYCLE_VALID && state_q.amask == 32'hFFFF_FFFF && !state_q.dcmp
            && state_q.qual == 8'hBC) |=> O_MATCH_I_B
    ) else $error("fully masked I cycle failed to match");

    // Data mismatch on unmasked bits blocks a long match
    AST_DATA_MASKED: assert property ( // RL3
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        (state_q.dcmp && state_q.qual[bcb_pkg::POS_SIZE +: 2] == bcb_pkg::SZ_LONG
            && (((I_L_SIDE_DATA_BUS ^ state_q.data) & ~state_q.dmask) != 32'h0000_0000))
        |=> !O_MATCH_L_B
    ) else $error("L match despite unmasked data difference");

    // An I match with data compare on implies the unmasked low lanes agreed
    AST_DATA_LANES: assert property ( // RL4
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        O_MATCH_I_B && $past(state_q.dcmp) |-> ((($past(I_I_SIDE_DATA_BUS)
            ^ $past(state_q.data)) & ~$past(state_q.dmask)
            & bcb_pkg::LANE_LOW16) == 32'h0000_0000)
    ) else $error("I match with low data lanes differing");

    // Bus field routes matches to one bus only
    AST_BUS_SELECT: assert property ( // RL8
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        (state_q.qual[bcb_pkg::POS_BUS +: 2] == bcb_pkg::BUS_I) |=> !O_MATCH_L_B
    ) else $error("L match while I bus selected");

    // Type field zero keeps the channel silent
    AST_TYPE_OFF: assert property ( // RL9
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        (state_q.qual[bcb_pkg::POS_TYPE +: 2] == bcb_pkg::SEL_OFF) [*2] |-> !O_MATCH_B
    ) else $error("match with cycle type comparison off");

    // Read-only direction never matches a write
    AST_DIR_READ: assert property ( // RL10
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        O_MATCH_L_B && $past(state_q.qual[bcb_pkg::POS_DIR +: 2]) == bcb_pkg::SEL_A
        |-> !$past(I_L_WRITE)
    ) else $error("write cycle matched a read-only condition");

    // Nonzero size field must equal the cycle size
    AST_SIZE_EQ: assert property ( // RL11
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        O_MATCH_I_B && $past(state_q.qual[bcb_pkg::POS_SIZE +: 2]) != bcb_pkg::SEL_OFF
        |-> $past(I_I_SIZE) == $past(state_q.qual[bcb_pkg::POS_SIZE +: 2])
    ) else $error("I match with wrong operand size");

    // A written word reads back on the next read
    AST_WRITE_READBACK: assert property ( // RL13
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        (apb_done && I_PWRITE && I_PADDR == bcb_pkg::OFS_DATA)
        ##3 (apb_first && !I_PWRITE && I_PADDR == bcb_pkg::OFS_DATA)
        |=> O_PRDATA == $past(I_PWDATA, 4)
    ) else $error("break data readback differs");

    // Combined match is the OR of the two buses
    AST_MATCH_OR: assert property ( // RL15
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        O_MATCH_B == (O_MATCH_L_B || O_MATCH_I_B)
    ) else $error("combined match disagrees with bus matches");

    // Bus field zero keeps both buses silent
    AST_BUS_OFF: assert property ( // RL8
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        (state_q.qual[bcb_pkg::POS_BUS +: 2] == bcb_pkg::SEL_OFF) |=> !O_MATCH_B
    ) else $error("match with bus comparison off");

    // Direction field zero keeps both buses silent
    AST_DIR_OFF: assert property ( // RL10
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        (state_q.qual[bcb_pkg::POS_DIR +: 2] == bcb_pkg::SEL_OFF) |=> !O_MATCH_B
    ) else $error("match with direction comparison off");

    // Equal address with open L fields and no data compare must match
    AST_L_HIT: assert property ( // RL15
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        (I_L_CYCLE_VALID && !state_q.dcmp && state_q.qual == 8'h7C
            && I_L_SIDE_ADDRESS_BUS == state_q.addr) |=> O_MATCH_L_B
    ) else $error("L cycle with all conditions met did not match");
endmodule : bcb_compare

// ===== verif/bcb_cpu_model.sv
// Behavioural model of one processor bus that presents cycles to the comparator
`timescale 1ns/1ps
module bcb_cpu_model (
    input wire logic i_clk,
    output logic o_valid,
    output logic [31:0] o_addr,
    output logic [31:0] o_data,
    output logic o_fetch,
    output logic o_write,
    output logic [1:0] o_size
);
    // Bus is idle until the first cycle is issued
    initial begin
        o_valid = 1'h0;
        o_addr = 32'h0000_0000;
        o_data = 32'h0000_0000;
        o_fetch = 1'h0;
        o_write = 1'h0;
        o_size = 2'h0;
    end

    // One cycle for one clock; afterwards lines show inverted values, not the old ones
    task automatic cycle(input logic [31:0] a, input logic [31:0] d, input logic f,
        input logic w, input logic [1:0] s);
        o_valid <= 1'h1;
        o_addr <= a;
        o_data <= d;
        o_fetch <= f;
        o_write <= w;
        o_size <= s;
        @(posedge i_clk);
        o_valid <= 1'h0;
        o_addr <= ~a;
        o_data <= ~d;
        o_fetch <= ~f;
        o_write <= ~w;
        o_size <= ~s;
    endtask : cycle
endmodule : bcb_cpu_model

// ===== verif/tb_bcb_compare.sv
// Self-checking bench for the channel B break compare block
`timescale 1ns/1ps
module tb_bcb_compare;
    logic clk = 1'h0;
    logic arst_n = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, m_l, m_i, m_b;
    // L and I bus lines from the two bus models
    logic lv, lf, lw, iv, jf, jw;
    logic [31:0] la, ld, ia, jd;
    logic [1:0] ls, js;
    int error_cnt = 0;
    int checks_done = 0;
    logic [31:0] rd;
    logic er, f, w;
    logic [1:0] s;

    // 20 MHz clock
    always #25 clk = ~clk;

    bcb_cpu_model u_lbus (.i_clk(clk), .o_valid(lv), .o_addr(la), .o_data(ld),
        .o_fetch(lf), .o_write(lw), .o_size(ls));
    bcb_cpu_model u_ibus (.i_clk(clk), .o_valid(iv), .o_addr(ia), .o_data(jd),
        .o_fetch(jf), .o_write(jw), .o_size(js));
    bcb_compare DUT (.I_CLOCK(clk), .I_ARST_N(arst_n), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_L_CYCLE_VALID(lv),
        .I_L_SIDE_ADDRESS_BUS(la), .I_L_SIDE_DATA_BUS(ld), .I_L_FETCH(lf), .I_L_WRITE(lw),
        .I_L_SIZE(ls), .I_I_CYCLE_VALID(iv), .I_I_SIDE_ADDRESS_BUS(ia),
        .I_I_SIDE_DATA_BUS(jd), .I_I_FETCH(jf), .I_I_WRITE(jw), .I_I_SIZE(js),
        .O_MATCH_L_B(m_l), .O_MATCH_I_B(m_i), .O_MATCH_B(m_b));

    // Compare one observed value with the expected one
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer: setup, access, hold until ready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        // Wait for the answer; only the watchdog ends a hung access
        while (pready !== 1'h1) begin
            @(posedge clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    // Expected qualifier outcome for one bus cycle
    function automatic logic rq(input logic [7:0] q, input logic ib, input logic fe,
        input logic wi, input logic [1:0] sz);
        return (q[7:6] != 2'h0) && (ib ? (q[7:6] == 2'h2) : (q[7:6] != 2'h2))
            && (q[5:4] == 2'h3 || q[5:4] == (fe ? 2'h1 : 2'h2))
            && (q[3:2] == 2'h3 || q[3:2] == (wi ? 2'h2 : 2'h1))
            && (q[1:0] == 2'h0 || q[1:0] == sz);
    endfunction : rq

    // Same-clock cycle on both buses (I gets inverted kind and direction), match checked
    task automatic cyc(input logic [31:0] a, input logic [31:0] d, input logic fe,
        input logic wi, input logic [1:0] sz, input logic el, input logic ei);
        @(posedge clk);
        fork
            u_lbus.cycle(a, d, fe, wi, sz);
            u_ibus.cycle(a, d, !fe, !wi, sz);
        join
        #1;
        chk({31'h0, m_l}, {31'h0, el});
        chk({31'h0, m_i}, {31'h0, ei});
        chk({31'h0, m_b}, {31'h0, el | ei});
    endtask : cyc

    // Print counts and the verdict, then stop
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    // Watchdog well past the expected run of about 7300 cycles
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        test_done();
    end

    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'h1;
        // Reset values of every mapped register, then an unmapped read
        for (int i = 0; i < 7; i++) begin
            apb(1'h0, 8'(4 * i), 32'h0);
            chk(rd, 32'h0);
            chk({31'h0, er}, 32'h0);
        end
        apb(1'h0, 8'h1C, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        // Ready stands for one cycle only
        @(posedge clk);
        chk({31'h0, pready}, 32'h0);
        cyc(32'h0, 32'h0, 1'h0, 1'h0, 2'h3, 1'h0, 1'h0);
        $display("test reset done");
        // Read back; the qualifier keeps its low byte only
        for (int i = 0; i < 5; i++) begin
            apb(1'h1, 8'(4 * i), 32'hA5C3_F0FF ^ 32'(i));
            apb(1'h0, 8'(4 * i), 32'h0);
            chk(rd, (i == 4) ? 32'h0000_00FB : (32'hA5C3_F0FF ^ 32'(i)));
        end
        $display("test registers done");
        // Address compare: L bus, any kind, any direction, any size
        apb(1'h1, bcb_pkg::OFS_ADDR, 32'h1234_5678);
        apb(1'h1, bcb_pkg::OFS_AMASK, 32'h0);
        apb(1'h1, bcb_pkg::OFS_DMASK, 32'h0);
        apb(1'h1, bcb_pkg::OFS_QUAL, 32'h7C);
        cyc(32'h1234_5678, 32'h0, 1'h0, 1'h0, 2'h3, 1'h1, 1'h0);
        cyc(32'h1234_5679, 32'h0, 1'h0, 1'h0, 2'h3, 1'h0, 1'h0);
        apb(1'h1, bcb_pkg::OFS_AMASK, 32'h0000_00FF);
        cyc(32'h1234_56A9, 32'h0, 1'h0, 1'h0, 2'h3, 1'h1, 1'h0);
        cyc(32'h1234_5778, 32'h0, 1'h0, 1'h0, 2'h3, 1'h0, 1'h0);
        // Fully masked address on the I bus matches any address
        apb(1'h1, bcb_pkg::OFS_AMASK, 32'hFFFF_FFFF);
        apb(1'h1, bcb_pkg::OFS_QUAL, 32'hBC);
        cyc(32'h8765_4321, 32'h0, 1'h0, 1'h0, 2'h2, 1'h0, 1'h1);
        $display("test address done");
        // Every qualifier value against every kind, direction and size
        for (int q = 0; q < 256; q++) begin
            apb(1'h1, bcb_pkg::OFS_QUAL, 32'(q));
            for (int k = 0; k < 12; k++) begin
                f = k[0];
                w = k[1];
                s = 2'(k / 4 + 1);
                cyc(32'h1234_5678, 32'h0, f, w, s, rq(8'(q), 1'h0, f, w, s),
                    rq(8'(q), 1'h1, !f, !w, s));
            end
        end
        $display("test qualifier done");
        // Data compare with longword size, then byte size with duplicated lanes
        apb(1'h1, bcb_pkg::OFS_CTRL, 32'h1);
        apb(1'h1, bcb_pkg::OFS_QUAL, 32'h7F);
        apb(1'h1, bcb_pkg::OFS_DATA, 32'hCAFE_0123);
        apb(1'h1, bcb_pkg::OFS_DMASK, 32'h0);
        cyc(32'h1234_5678, 32'hCAFE_0123, 1'h0, 1'h0, 2'h3, 1'h1, 1'h0);
        cyc(32'h1234_5678, 32'h4AFE_0123, 1'h0, 1'h0, 2'h3, 1'h0, 1'h0);
        apb(1'h1, bcb_pkg::OFS_DMASK, 32'h8000_0000);
        cyc(32'h1234_5678, 32'h4AFE_0123, 1'h0, 1'h0, 2'h3, 1'h1, 1'h0);
        apb(1'h1, bcb_pkg::OFS_QUAL, 32'h7D);
        apb(1'h1, bcb_pkg::OFS_DATA, 32'h0000_4545);
        apb(1'h1, bcb_pkg::OFS_DMASK, 32'h0000_0101);
        cyc(32'h1234_5678, 32'hFFFF_4444, 1'h0, 1'h0, 2'h1, 1'h1, 1'h0);
        cyc(32'h1234_5678, 32'h0000_4645, 1'h0, 1'h0, 2'h1, 1'h0, 1'h0);
        cyc(32'h1234_5678, 32'h0000_4545, 1'h0, 1'h0, 2'h2, 1'h0, 1'h0);
        // Byte data compare on the I bus, upper lanes ignored
        apb(1'h1, bcb_pkg::OFS_QUAL, 32'hBD);
        cyc(32'h1234_5678, 32'hFFFF_4444, 1'h0, 1'h0, 2'h1, 1'h0, 1'h1);
        cyc(32'h1234_5678, 32'h0000_4645, 1'h0, 1'h0, 2'h1, 1'h0, 1'h0);
        $display("test data done");
        test_done();
    end
endmodule : tb_bcb_compare
